// *** scs_pkg.sv ***
// system clock select unit: register map, field positions, reset values,
// timing counts and state encoding shared by the design files.
// assumes a 10 MHz reference clock and a 32-bit apb slave port.
`default_nettype none

package scs_pkg;

   // register byte addresses
   localparam logic [31:0] SCS_MAIN_SEL_ADDR = 32'h4000401c;
   localparam logic [31:0] SCS_CPU_SEL_ADDR  = 32'h40004020;
   localparam logic [31:0] SCS_IRQ_STAT_ADDR = 32'h40004024;
   localparam logic [31:0] SCS_IRQ_MASK_ADDR = 32'h40004028;
   localparam logic [31:0] SCS_RC_TRIM_ADDR  = 32'h4000402c;
   localparam logic [31:0] SCS_KHZ_STEP_ADDR = 32'h40004030;
   localparam logic [31:0] SCS_STATUS_ADDR   = 32'h40004034;

   // decoded register index, 0 means unmapped
   localparam logic [2:0] SCS_IDX_NONE  = 3'h0;
   localparam logic [2:0] SCS_IDX_MAIN  = 3'h1;
   localparam logic [2:0] SCS_IDX_CPU   = 3'h2;
   localparam logic [2:0] SCS_IDX_STAT  = 3'h3;
   localparam logic [2:0] SCS_IDX_MASK  = 3'h4;
   localparam logic [2:0] SCS_IDX_TRIM  = 3'h5;
   localparam logic [2:0] SCS_IDX_STEP  = 3'h6;
   localparam logic [2:0] SCS_IDX_STATE = 3'h7;

   // field positions
   localparam int SCS_MAIN_SEL_BIT  = 0;
   localparam int SCS_MAIN_EN_BIT   = 1;
   localparam int SCS_CPU_FAST_BIT  = 0;
   localparam int SCS_IRQ_FAIL_BIT  = 0;
   localparam int SCS_IRQ_SWTCH_BIT = 1;
   localparam int SCS_ST_XTAL_BIT   = 0;
   localparam int SCS_ST_FAST_BIT   = 1;
   localparam int SCS_ST_FAIL_BIT   = 2;
   localparam int SCS_ST_FLASH_BIT  = 3;
   localparam int SCS_ST_CAL_LSB    = 16;

   // reset values
   localparam logic       SCS_MAIN_SEL_RST = 1'b0;
   localparam logic       SCS_MAIN_EN_RST  = 1'b0;
   localparam logic       SCS_CPU_FAST_RST = 1'b0;
   localparam logic [1:0] SCS_IRQ_MASK_RST = 2'h0;
   localparam logic [5:0] SCS_TRIM_RST     = 6'h00;
   localparam logic [15:0] SCS_STEP_RST    = 16'h199a;

   // oscillator pin indices
   localparam int SCS_OSC_FAST_RC = 0;
   localparam int SCS_OSC_XTAL    = 1;
   localparam int SCS_OSC_SLOW_RC = 2;
   localparam int SCS_OSC_WATCH   = 3;
   localparam int SCS_OSC_NUM     = 4;

   // timing
   localparam int SCS_CLK_PERIOD_NS    = 100;
   localparam int SCS_XTAL_TIMEOUT_NS  = 10000;
   localparam logic [7:0] SCS_XTAL_TIMEOUT_CYC =
      8'((SCS_XTAL_TIMEOUT_NS + SCS_CLK_PERIOD_NS - 1) / SCS_CLK_PERIOD_NS);
   localparam logic [7:0] SCS_CAL_WINDOW = 8'hff;

   // source state, gray along rc -> crystal -> rc
   typedef enum logic [1:0] {
      SCS_ST_RC      = 2'b00,
      SCS_ST_TO_XTAL = 2'b01,
      SCS_ST_XTAL    = 2'b11,
      SCS_ST_TO_RC   = 2'b10
   } scs_src_e;

endpackage

`default_nettype wire

// *** scs_edge_sync.sv ***
// two-flop synchroniser for an oscillator pin with rising-edge pulse out.
// assumes the pin toggles slower than half the reference clock.
`default_nettype none

module scs_edge_sync
   import scs_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk_in,
   input  wire logic rstn_in,
   // pin and pulse
   input  wire logic pin_in,
   output logic      rise_out
);

   logic meta_reg;
   logic sync_reg;
   logic last_reg;
   logic rise_reg;
   logic rise_next;

   // first flop feeds only the second
   always_comb
   begin
      rise_next = sync_reg & ~last_reg;
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
         rise_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
         rise_reg <= rise_next;
      end
   end

   assign rise_out = rise_reg;

endmodule

`default_nettype wire

// *** scs_clock_select.sv ***
// system clock select unit: picks rc or crystal as system clock, derives
// peripheral, processor and ram clock enables, crystal failover, 1 kHz ref.
// assumes oscillator pins arrive asynchronous; flash busy is same-clock logic.
//
// Design decision made here: the APB register port.
`default_nettype none

module scs_clock_select
   import scs_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rstn_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [31:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // oscillator pins
   input  wire logic        fast_rc_oscillator_in,
   input  wire logic        main_crystal_oscillator_in,
   input  wire logic        slow_rc_oscillator_in,
   input  wire logic        watch_crystal_oscillator_in,
   // flash controller
   input  wire logic        flash_busy_in,
   // clock enables and fast rc trim
   output logic             sys_clk_en_out,
   output logic             periph_clk_en_out,
   output logic             processor_clock_en_out,
   output logic             ram_clk_en_out,
   output logic             one_khz_reference_out,
   output logic             watch_tick_out,
   output logic      [5:0]  fast_rc_trim_out,
   // interrupts
   output logic             nmi_out,
   output logic             irq_out
);

   ////////////////////////////////////////////////////////////////////////////
   // oscillator pin synchronisers

   logic [SCS_OSC_NUM-1:0] osc_pin;
   logic [SCS_OSC_NUM-1:0] osc_rise;

   assign osc_pin[SCS_OSC_FAST_RC] = fast_rc_oscillator_in;
   assign osc_pin[SCS_OSC_XTAL]    = main_crystal_oscillator_in;
   assign osc_pin[SCS_OSC_SLOW_RC] = slow_rc_oscillator_in;
   assign osc_pin[SCS_OSC_WATCH]   = watch_crystal_oscillator_in;

   genvar gi;
   generate
      for (gi = 0; gi < SCS_OSC_NUM; gi++)
      begin : g_sync
         scs_edge_sync u_sync (
            .ref_clk_in (ref_clk_in),
            .rstn_in    (rstn_in),
            .pin_in     (osc_pin[gi]),
            .rise_out   (osc_rise[gi])
         );
      end
   endgenerate

   wire logic rc_rise   = osc_rise[SCS_OSC_FAST_RC];
   wire logic xtal_rise = osc_rise[SCS_OSC_XTAL];

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   function automatic logic [2:0] reg_index(input logic [31:0] addr);
      if (addr == SCS_MAIN_SEL_ADDR)
         reg_index = SCS_IDX_MAIN;
      else if (addr == SCS_CPU_SEL_ADDR)
         reg_index = SCS_IDX_CPU;
      else if (addr == SCS_IRQ_STAT_ADDR)
         reg_index = SCS_IDX_STAT;
      else if (addr == SCS_IRQ_MASK_ADDR)
         reg_index = SCS_IDX_MASK;
      else if (addr == SCS_RC_TRIM_ADDR)
         reg_index = SCS_IDX_TRIM;
      else if (addr == SCS_KHZ_STEP_ADDR)
         reg_index = SCS_IDX_STEP;
      else if (addr == SCS_STATUS_ADDR)
         reg_index = SCS_IDX_STATE;
      else
         reg_index = SCS_IDX_NONE;
   endfunction

   logic [2:0] idx;
   logic       wr_acc;
   logic       rd_acc;

   assign idx      = reg_index(paddr_in);
   assign wr_acc   = psel_in & penable_in & pwrite_in;
   assign rd_acc   = psel_in & penable_in & ~pwrite_in;

   ////////////////////////////////////////////////////////////////////////////
   // state

   scs_src_e    src_reg,        src_next;
   logic        main_sel_reg,   main_sel_next;
   logic        main_en_reg,    main_en_next;
   logic        cpu_fast_reg,   cpu_fast_next;
   logic        fast_eff_reg,   fast_eff_next;
   logic        pdiv_reg,       pdiv_next;
   logic        xtal_fail_reg,  xtal_fail_next;
   logic [7:0]  wd_cnt_reg,     wd_cnt_next;
   logic [1:0]  irq_stat_reg,   irq_stat_next;
   logic [1:0]  irq_mask_reg,   irq_mask_next;
   logic [5:0]  trim_reg,       trim_next;
   logic [15:0] step_reg,       step_next;
   logic [15:0] khz_acc_reg,    khz_acc_next;
   logic [7:0]  cal_win_reg,    cal_win_next;
   logic [11:0] cal_cnt_reg,    cal_cnt_next;
   logic [11:0] cal_res_reg,    cal_res_next;
   logic [31:0] prdata_reg,     prdata_next;
   logic        pslverr_reg,    pslverr_next;
   logic        sys_tick_reg,   sys_tick_next;
   logic        per_tick_reg,   per_tick_next;
   logic        proc_tick_reg,  proc_tick_next;
   logic        ram_tick_reg,   ram_tick_next;
   logic        khz_tick_reg,   khz_tick_next;
   logic        watch_reg,      watch_next;
   logic        nmi_reg,        nmi_next;
   logic        irq_reg,        irq_next;
   logic        pready_reg;

   logic        xtal_req;
   logic        xtal_src_next;
   logic        fail_evt;
   logic        switch_evt;
   logic        sys_tick_c;
   logic        per_tick_c;
   logic [16:0] khz_sum;

   ////////////////////////////////////////////////////////////////////////////
   // source selection and clock enables

   always_comb
   begin
      xtal_req      = main_sel_reg | main_en_reg;
      fail_evt      = 1'b0;
      switch_evt    = 1'b0;
      src_next      = src_reg;
      wd_cnt_next   = 8'h00;
      xtal_fail_next = xtal_fail_reg;

      // crystal watchdog only while the crystal is wanted or in use
      if ((src_reg != SCS_ST_RC) && !xtal_fail_reg && !xtal_rise)
      begin
         wd_cnt_next = wd_cnt_reg + 8'h01;
         if (wd_cnt_reg == SCS_XTAL_TIMEOUT_CYC - 8'h01)
            fail_evt = 1'b1;
      end
      if (fail_evt)
         xtal_fail_next = 1'b1;
      else if (wr_acc && idx == SCS_IDX_MAIN)
         xtal_fail_next = 1'b0;                            // rewrite retries crystal

      // requested switches land on the even sysclk edge so pclk never gets a short half; failover switches at once
      case (src_reg)
         SCS_ST_RC:
         begin
            if (xtal_req && !xtal_fail_reg)
               src_next = SCS_ST_TO_XTAL;
         end
         SCS_ST_TO_XTAL:
         begin
            if (fail_evt || !xtal_req)
               src_next = SCS_ST_RC;
            else if (!pdiv_reg && xtal_rise)
            begin
               src_next   = SCS_ST_XTAL;
               switch_evt = 1'b1;
            end
         end
         SCS_ST_XTAL:
         begin
            if (fail_evt)
            begin
               src_next   = SCS_ST_RC;
               switch_evt = 1'b1;
            end
            else if (!xtal_req)
               src_next = SCS_ST_TO_RC;
         end
         SCS_ST_TO_RC:
         begin
            if (fail_evt)
            begin
               src_next   = SCS_ST_RC;
               switch_evt = 1'b1;
            end
            else if (xtal_req)
               src_next = SCS_ST_XTAL;
            else if (!pdiv_reg && rc_rise)
            begin
               src_next   = SCS_ST_RC;
               switch_evt = 1'b1;
            end
         end
         default:
            src_next = SCS_ST_RC;
      endcase

      xtal_src_next = (src_next == SCS_ST_XTAL) || (src_next == SCS_ST_TO_RC);
      sys_tick_c    = xtal_src_next ? xtal_rise : rc_rise;
      per_tick_c    = sys_tick_c & pdiv_reg;
      pdiv_next     = sys_tick_c ? ~pdiv_reg : pdiv_reg;

      // cpu mode only changes on a pclk boundary, never mid-period
      fast_eff_next = fast_eff_reg;
      if (sys_tick_c && !pdiv_reg)
      begin
         if (flash_busy_in)
            fast_eff_next = ~xtal_src_next;
         else
            fast_eff_next = cpu_fast_reg;
      end

      sys_tick_next  = sys_tick_c;
      per_tick_next  = per_tick_c;
      proc_tick_next = fast_eff_reg ? sys_tick_c : per_tick_c;
      // ram runs at sysclk rate in both modes: the processor rate in fast, double it in normal
      ram_tick_next  = fast_eff_reg ? proc_tick_next : sys_tick_c;
      watch_next     = osc_rise[SCS_OSC_WATCH];
      nmi_next       = fail_evt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // 1 kHz reference and fast rc calibration counter

   always_comb
   begin
      khz_sum       = {1'b0, khz_acc_reg} + {1'b0, step_reg};
      khz_acc_next  = khz_acc_reg;
      khz_tick_next = 1'b0;
      if (osc_rise[SCS_OSC_SLOW_RC])
      begin
         khz_acc_next  = khz_sum[15:0];
         khz_tick_next = khz_sum[16];
      end

      // rc edges per crystal window, read back to trim the rc
      cal_win_next = cal_win_reg;
      cal_cnt_next = cal_cnt_reg;
      cal_res_next = cal_res_reg;
      if (rc_rise && cal_cnt_reg != 12'hfff)
         cal_cnt_next = cal_cnt_reg + 12'h001;
      if (xtal_rise)
      begin
         cal_win_next = cal_win_reg + 8'h01;
         if (cal_win_reg == SCS_CAL_WINDOW)
         begin
            cal_res_next = cal_cnt_reg;
            cal_cnt_next = 12'h000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers and interrupts

   always_comb
   begin
      main_sel_next = main_sel_reg;
      main_en_next  = main_en_reg;
      cpu_fast_next = cpu_fast_reg;
      irq_mask_next = irq_mask_reg;
      trim_next     = trim_reg;
      step_next     = step_reg;
      irq_stat_next = irq_stat_reg;
      prdata_next   = prdata_reg;
      pslverr_next  = pslverr_reg;

      if (wr_acc)
      begin
         if (idx == SCS_IDX_MAIN)
         begin
            main_sel_next = pwdata_in[SCS_MAIN_SEL_BIT];
            main_en_next  = pwdata_in[SCS_MAIN_EN_BIT];
         end
         else if (idx == SCS_IDX_CPU)
            cpu_fast_next = pwdata_in[SCS_CPU_FAST_BIT];
         else if (idx == SCS_IDX_MASK)
            irq_mask_next = pwdata_in[1:0];
         else if (idx == SCS_IDX_TRIM)
            trim_next = pwdata_in[5:0];
         else if (idx == SCS_IDX_STEP)
            step_next = pwdata_in[15:0];
      end
      // failover overrides any software selection
      if (fail_evt)
      begin
         main_sel_next = 1'b0;
         main_en_next  = 1'b0;
      end

      // read clears, but a same-cycle event still lands
      if (rd_acc && idx == SCS_IDX_STAT)
         irq_stat_next = 2'h0;
      if (fail_evt)
         irq_stat_next[SCS_IRQ_FAIL_BIT] = 1'b1;
      if (switch_evt)
         irq_stat_next[SCS_IRQ_SWTCH_BIT] = 1'b1;

      if (psel_in && !penable_in)
      begin
         pslverr_next = (idx == SCS_IDX_NONE);
         prdata_next  = 32'h00000000;
         if (idx == SCS_IDX_MAIN)
         begin
            prdata_next[SCS_MAIN_SEL_BIT] = main_sel_reg;
            prdata_next[SCS_MAIN_EN_BIT]  = (src_reg == SCS_ST_XTAL) ||
                                            (src_reg == SCS_ST_TO_RC);
         end
         else if (idx == SCS_IDX_CPU)
            prdata_next[SCS_CPU_FAST_BIT] = cpu_fast_reg;
         else if (idx == SCS_IDX_STAT)
            prdata_next[1:0] = irq_stat_reg;
         else if (idx == SCS_IDX_MASK)
            prdata_next[1:0] = irq_mask_reg;
         else if (idx == SCS_IDX_TRIM)
            prdata_next[5:0] = trim_reg;
         else if (idx == SCS_IDX_STEP)
            prdata_next[15:0] = step_reg;
         else if (idx == SCS_IDX_STATE)
         begin
            prdata_next[SCS_ST_XTAL_BIT]  = (src_reg == SCS_ST_XTAL) ||
                                            (src_reg == SCS_ST_TO_RC);
            prdata_next[SCS_ST_FAST_BIT]  = fast_eff_reg;
            prdata_next[SCS_ST_FAIL_BIT]  = xtal_fail_reg;
            prdata_next[SCS_ST_FLASH_BIT] = flash_busy_in;
            prdata_next[SCS_ST_CAL_LSB +: 12] = cal_res_reg;
         end
      end
      if (!psel_in)
         pslverr_next = 1'b0;

      irq_next = |(irq_stat_next & irq_mask_reg);
   end

   ////////////////////////////////////////////////////////////////////////////
   // flops

   always_ff @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         src_reg       <= SCS_ST_RC;
         main_sel_reg  <= SCS_MAIN_SEL_RST;
         main_en_reg   <= SCS_MAIN_EN_RST;
         cpu_fast_reg  <= SCS_CPU_FAST_RST;
         fast_eff_reg  <= SCS_CPU_FAST_RST;
         pdiv_reg      <= 1'b0;
         xtal_fail_reg <= 1'b0;
         wd_cnt_reg    <= 8'h00;
         irq_stat_reg  <= 2'h0;
         irq_mask_reg  <= SCS_IRQ_MASK_RST;
         trim_reg      <= SCS_TRIM_RST;
         step_reg      <= SCS_STEP_RST;
         khz_acc_reg   <= 16'h0000;
         cal_win_reg   <= 8'h00;
         cal_cnt_reg   <= 12'h000;
         cal_res_reg   <= 12'h000;
         prdata_reg    <= 32'h00000000;
         pslverr_reg   <= 1'b0;
         pready_reg    <= 1'b0;
         sys_tick_reg  <= 1'b0;
         per_tick_reg  <= 1'b0;
         proc_tick_reg <= 1'b0;
         ram_tick_reg  <= 1'b0;
         khz_tick_reg  <= 1'b0;
         watch_reg     <= 1'b0;
         nmi_reg       <= 1'b0;
         irq_reg       <= 1'b0;
      end
      else
      begin
         src_reg       <= src_next;
         main_sel_reg  <= main_sel_next;
         main_en_reg   <= main_en_next;
         cpu_fast_reg  <= cpu_fast_next;
         fast_eff_reg  <= fast_eff_next;
         pdiv_reg      <= pdiv_next;
         xtal_fail_reg <= xtal_fail_next;
         wd_cnt_reg    <= wd_cnt_next;
         irq_stat_reg  <= irq_stat_next;
         irq_mask_reg  <= irq_mask_next;
         trim_reg      <= trim_next;
         step_reg      <= step_next;
         khz_acc_reg   <= khz_acc_next;
         cal_win_reg   <= cal_win_next;
         cal_cnt_reg   <= cal_cnt_next;
         cal_res_reg   <= cal_res_next;
         prdata_reg    <= prdata_next;
         pslverr_reg   <= pslverr_next;
         pready_reg    <= 1'b1;
         sys_tick_reg  <= sys_tick_next;
         per_tick_reg  <= per_tick_next;
         proc_tick_reg <= proc_tick_next;
         ram_tick_reg  <= ram_tick_next;
         khz_tick_reg  <= khz_tick_next;
         watch_reg     <= watch_next;
         nmi_reg       <= nmi_next;
         irq_reg       <= irq_next;
      end
   end

   assign prdata_out             = prdata_reg;
   assign pready_out             = pready_reg;
   assign pslverr_out            = pslverr_reg;
   assign sys_clk_en_out         = sys_tick_reg;
   assign periph_clk_en_out      = per_tick_reg;
   assign processor_clock_en_out = proc_tick_reg;
   assign ram_clk_en_out         = ram_tick_reg;
   assign one_khz_reference_out  = khz_tick_reg;
   assign watch_tick_out         = watch_reg;
   assign fast_rc_trim_out       = trim_reg;
   assign nmi_out                = nmi_reg;
   assign irq_out                = irq_reg;

endmodule

`default_nettype wire

// *** scs_osc_model.sv ***
// far side model: oscillator pins and the flash controller busy level.
// assumes the bench gates the crystal and flash through the two enables.
`default_nettype none
module scs_osc_model
   import scs_pkg::*;
#(
   parameter int RC_HALF = 300,
   parameter int XT_HALF = 140,
   parameter int SL_HALF = 2000,
   parameter int WA_HALF = 1700
)
(
   // clock and controls
   input  wire logic ref_clk_in,
   input  wire logic xtal_on_in,
   input  wire logic flash_on_in,
   // pins
   output var logic  fast_rc_oscillator_out,
   output var logic  main_crystal_oscillator_out,
   output var logic  slow_rc_oscillator_out,
   output var logic  watch_crystal_oscillator_out,
   output var logic  flash_busy_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      {fast_rc_oscillator_out, main_crystal_oscillator_out, slow_rc_oscillator_out} = 3'h0;
      {watch_crystal_oscillator_out, flash_busy_out} = 2'h0;
   end
   // half periods end in 0 ns, so no pin moves on a rising clock edge
   always #(RC_HALF) fast_rc_oscillator_out = ~fast_rc_oscillator_out;
   // a dead crystal stands still rather than running slow
   always #(XT_HALF) if (xtal_on_in) main_crystal_oscillator_out = ~main_crystal_oscillator_out;
   always #(SL_HALF) slow_rc_oscillator_out = ~slow_rc_oscillator_out;
   always #(WA_HALF) watch_crystal_oscillator_out = ~watch_crystal_oscillator_out;
   always @(posedge ref_clk_in) flash_busy_out <= flash_on_in;
endmodule
`default_nettype wire

// *** scs_clock_select_checker.sv ***
// assertions on the clock enables, apb handshake, nmi and trim.
// assumes it is bound to scs_clock_select and sees only its ports.
`default_nettype none
module scs_clock_select_checker
   import scs_pkg::*;
(
   input wire logic       ref_clk_in,
   input wire logic       rstn_in,
   input wire logic       psel_in,
   input wire logic       penable_in,
   input wire logic       pwrite_in,
   input wire logic       pready_out,
   input wire logic       watch_crystal_oscillator_in,
   input wire logic       sys_clk_en_out,
   input wire logic       periph_clk_en_out,
   input wire logic       processor_clock_en_out,
   input wire logic       ram_clk_en_out,
   input wire logic       watch_tick_out,
   input wire logic [5:0] fast_rc_trim_out,
   input wire logic       nmi_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   wire logic wr = psel_in && penable_in && pwrite_in;
   // sys pulses seen since the last peripheral pulse
   logic [1:0] gap_reg;
   logic [1:0] gap_next;
   always_comb
   begin
      gap_next = gap_reg;
      if (periph_clk_en_out)
         gap_next = 2'h0;
      else if (sys_clk_en_out && gap_reg != 2'h3)
         gap_next = gap_reg + 2'h1;
   end
   always_ff @(posedge ref_clk_in)
   begin
      if (!rstn_in)
         gap_reg <= 2'h0;
      else
         gap_reg <= gap_next;
   end
   sequence s_access;
      psel_in && penable_in;
   endsequence
   sequence s_watch_rise;
      $rose(watch_crystal_oscillator_in);
   endsequence
   property p_pready;
      s_access |-> pready_out;
   endproperty
   a_pready: assert property (p_pready) else $error("pready low in access");
   property p_periph_sub;
      periph_clk_en_out |-> sys_clk_en_out;
   endproperty
   a_periph_sub: assert property (p_periph_sub) else $error("lone periph pulse");
   property p_periph_alt;
      periph_clk_en_out |-> gap_reg == 2'h1;
   endproperty
   a_periph_alt: assert property (p_periph_alt) else $error("periph not half");
   property p_proc_sub;
      processor_clock_en_out |-> sys_clk_en_out;
   endproperty
   a_proc_sub: assert property (p_proc_sub) else $error("lone proc pulse");
   property p_ram;
      ram_clk_en_out == sys_clk_en_out;
   endproperty
   a_ram: assert property (p_ram) else $error("ram clock off");
   property p_nmi;
      $rose(nmi_out) |=> !nmi_out [*2];
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi too long");
   property p_watch;
      s_watch_rise |-> ##[1:5] watch_tick_out;
   endproperty
   a_watch: assert property (p_watch) else $error("watch tick missing");
   property p_trim;
      !wr |=> $stable(fast_rc_trim_out);
   endproperty
   a_trim: assert property (p_trim) else $error("trim moved");
endmodule
bind scs_clock_select scs_clock_select_checker scs_clock_select_checker_inst (.*);
`default_nettype wire

// *** tb_scs_clock_select.sv ***
// bench for the clock select unit: modes, failover, irq, apb, 1 kHz.
// assumes the oscillator model drives the pins and the flash level.
`default_nettype none
module tb_scs_clock_select
   import scs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int WIN = 240;
   logic        ref_clk_in = 1'h0;
   logic        rstn_in = 1'h0;
   logic        psel_in = 1'h0;
   logic        penable_in = 1'h0;
   logic        pwrite_in = 1'h0;
   logic [31:0] paddr_in = 32'h0;
   logic [31:0] pwdata_in = 32'h0;
   logic        xtal_on = 1'h1;
   logic        flash_on = 1'h0;
   logic [31:0] prdata_out;
   logic [5:0]  fast_rc_trim_out;
   logic        pready_out, pslverr_out, flash_busy_in, nmi_out, irq_out;
   logic        perr;
   logic        fast_rc_oscillator_in, main_crystal_oscillator_in;
   logic        slow_rc_oscillator_in, watch_crystal_oscillator_in;
   logic        sys_clk_en_out, periph_clk_en_out, processor_clock_en_out;
   logic        ram_clk_en_out, one_khz_reference_out, watch_tick_out;
   int          err_total = 0;
   int          tests_run = 0;
   int          cnt[5];
   always #50 ref_clk_in = ~ref_clk_in;
   scs_clock_select scs_clock_select_inst (.*);
   scs_osc_model scs_osc_model_inst (.ref_clk_in, .xtal_on_in(xtal_on),
      .flash_on_in(flash_on), .fast_rc_oscillator_out(fast_rc_oscillator_in),
      .main_crystal_oscillator_out(main_crystal_oscillator_in),
      .slow_rc_oscillator_out(slow_rc_oscillator_in),
      .watch_crystal_oscillator_out(watch_crystal_oscillator_in),
      .flash_busy_out(flash_busy_in));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, got, input int tol = 0);
      tests_run++;
      if ($isunknown(got) || got + tol < ex || got > ex + tol)
      begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      int k;
      psel_in <= 1'h1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge ref_clk_in);
      penable_in <= 1'h1;
      k = 0;
      do
      begin
         @(posedge ref_clk_in);
         k++;
      end
      while (pready_out !== 1'h1 && k < 16);
      r = prdata_out;
      perr = pslverr_out;
      if (pready_out !== 1'h1)
      begin
         err_total++;
         end_sim();
      end
      psel_in <= 1'h0;
      penable_in <= 1'h0;
      @(posedge ref_clk_in);
   endtask
   // enables seen per edge: sys, periph, proc, 1 khz, watch
   task automatic count(input int n);
      cnt = '{default: 0};
      repeat (n)
      begin
         @(posedge ref_clk_in);
         cnt[0] += sys_clk_en_out;
         cnt[1] += periph_clk_en_out;
         cnt[2] += processor_clock_en_out;
         cnt[3] += one_khz_reference_out;
         cnt[4] += watch_tick_out;
      end
   endtask
   function automatic int exp_proc(input logic [2:0] m, input int s, input int p);
      if (m[0])
         return m[2] ? p : s;
      return m[1] ? s : p;
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] rd;
      logic [31:0] wd;
      logic [2:0]  m;
      int          k;
      void'($urandom(83));
      repeat (8) @(posedge ref_clk_in);
      rstn_in <= 1'h1;
      @(posedge ref_clk_in);
      apb(1'h0, SCS_MAIN_SEL_ADDR, 32'h0, rd);
      chk("main", 32'h0, rd);
      apb(1'h0, SCS_CPU_SEL_ADDR, 32'h0, rd);
      chk("cpu", 32'h0, rd);
      apb(1'h0, SCS_KHZ_STEP_ADDR, 32'h0, rd);
      chk("step", {16'h0, SCS_STEP_RST}, rd);
      chk("pslverr", 32'h0, {31'h0, perr});
      apb(1'h0, 32'h40004040, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      chk("pslverr", 32'h1, {31'h0, perr});
      wd = $urandom;
      apb(1'h1, SCS_RC_TRIM_ADDR, wd, rd);
      chk("trim", {26'h0, wd[5:0]}, {26'h0, fast_rc_trim_out});
      // every source, cpu speed and flash combination
      for (int i = 0; i < 8; i++)
      begin
         m = 3'(i);
         flash_on <= m[0];
         wd = $urandom;
         wd[1:0] = {1'h0, m[2]};
         apb(1'h1, SCS_MAIN_SEL_ADDR, wd, rd);
         apb(1'h1, SCS_CPU_SEL_ADDR, {31'h0, m[1]}, rd);
         k = 0;
         do
         begin
            apb(1'h0, SCS_MAIN_SEL_ADDR, 32'h0, rd);
            k++;
         end
         while (rd[1] !== m[2] && k < 20);
         chk("main", {30'h0, m[2], m[2]}, rd);
         // handover waits for an aligned pulse
         count(24);
         count(WIN);
         chk("sys", WIN * 100 / (m[2] ? 280 : 600), cnt[0], 1);
         chk("periph", cnt[0] / 2, cnt[1], 1);
         chk("proc", exp_proc(m, cnt[0], cnt[1]), cnt[2]);
      end
      flash_on <= 1'h0;
      apb(1'h0, SCS_IRQ_STAT_ADDR, 32'h0, rd);
      xtal_on <= 1'h0;
      k = 0;
      while (nmi_out !== 1'h1 && k < 300)
      begin
         @(posedge ref_clk_in);
         k++;
      end
      chk("nmi", 32'h1, {31'h0, nmi_out});
      chk("irq masked", 32'h0, {31'h0, irq_out});
      apb(1'h0, SCS_MAIN_SEL_ADDR, 32'h0, rd);
      chk("main", 32'h0, rd);
      apb(1'h0, SCS_STATUS_ADDR, 32'h0, rd);
      chk("status", 32'h6, rd & 32'hf);
      apb(1'h1, SCS_IRQ_MASK_ADDR, 32'h3, rd);
      repeat (2) @(posedge ref_clk_in);
      chk("irq", 32'h1, {31'h0, irq_out});
      apb(1'h0, SCS_IRQ_STAT_ADDR, 32'h0, rd);
      chk("irq status", 32'h3, rd);
      repeat (2) @(posedge ref_clk_in);
      chk("irq cleared", 32'h0, {31'h0, irq_out});
      apb(1'h1, SCS_KHZ_STEP_ADDR, 32'h8000, rd);
      count(1600);
      chk("khz", 1600 * 100 / 8000, cnt[3], 1);
      chk("watch", 1600 * 100 / 3400, cnt[4], 1);
      end_sim();
   end
endmodule
`default_nettype wire
